// >>> hdl/src_pkg.sv
package src_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int STOP_WAIT_NS = 34000;
  // Typical figure, so the exact quotient is used
  localparam int STOP_WAIT_CYC = STOP_WAIT_NS / CLK_PERIOD_NS;
  // Minimum low time that the pin driver must provide
  localparam int RESET_PIN_MIN_NS = 2000;
  localparam int STAB_BASE_CYC = 256;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WAIT_W = 20;
  localparam int STAB_SEL_W = 3;
  localparam int N_EVT = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAB_SEL = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_CAUSE = 8'h0C;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_RES_BIT = 2;
  localparam int CAUSE_WDT_BIT = 0;
  localparam int CAUSE_LVD_BIT = 1;
  localparam int STAT_PIN_BIT = 4;
  localparam int STAT_OPT_BIT = 5;
  localparam int STAT_PORT_BIT = 6;
  localparam int STAT_WAKE_BIT = 7;
  localparam int EVT_HALT_WAKE = 0;
  localparam int EVT_STOP_DONE = 1;
  localparam int EVT_RST_DONE = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] STAB_SEL_RST = 3'h4;
  localparam logic CTRL_RES_RST = 1'b1;
  localparam logic [1:0] CAUSE_RST = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_RUN = 3'h1,
    ST_HALT = 3'h2,
    ST_STOP = 3'h3,
    ST_OSC_START = 3'h4,
    ST_STAB_WAIT = 3'h5
  } src_state_t;

  typedef struct packed {
    logic sys_osc_en;
    logic lsi_osc_en;
    logic cpu_clk_en;
  } src_clk_ctrl_t;

  typedef struct packed {
    logic sys_rst_n;
    logic wdt_rst;
    logic lvd_rst;
  } src_rst_out_t;

endpackage : src_pkg

// >>> hdl/src_pin_sync.sv
`timescale 1ns/100ps
module src_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin and filtered level
  input wire logic din,
  output logic dout
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level only moves once two stages agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dout <= RST_VAL;
    end else if (s2_q == s3_q) begin
      dout <= s3_q;
    end
  end

endmodule : src_pin_sync

// >>> hdl/src_irq.sv
`timescale 1ns/100ps
module src_irq #(
  parameter int N = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Events and software access
  input wire logic [N-1:0] evt,
  input wire logic clr_we,
  input wire logic en_we,
  input wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0] status_q,
  output logic [N-1:0] enable_q,
  output logic irq
);

  if (N < 1 || N > 32) begin : g_bad_n
    $error("src_irq: N out of range");
  end

  // Set wins so an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(clr_we ? wdata : '0)) | evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      enable_q <= '0;
    end else if (en_we) begin
      enable_q <= wdata;
    end
  end

  assign irq = |(status_q & enable_q);

endmodule : src_irq

// >>> hdl/src_standby_reset.sv
`timescale 1ns/100ps
module src_standby_reset #(
  parameter int N_INT = 8,
  parameter int STOP_WAIT_CYCLES = src_pkg::STOP_WAIT_CYC,
  parameter int STAB_BASE_CYCLES = src_pkg::STAB_BASE_CYC
) (
  // Clock and power-on-clear reset
  input wire logic CLK,
  input wire logic NRST,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Reset sources
  input wire logic RESET_PIN_N,
  input wire logic WDT_OVERFLOW,
  input wire logic LOW_VOLTAGE_DETECTOR_RESET,
  // Option byte
  input wire logic OPT_VALID,
  input wire logic OPT_PIN_AS_PORT,
  input wire logic [2:0] OPT_STAB_SEL,
  // Interrupt sources
  input wire logic [N_INT-1:0] INT_REQ,
  input wire logic [N_INT-1:0] INT_MASK,
  // Oscillator
  input wire logic OSC_READY,
  output src_pkg::src_clk_ctrl_t CLOCK_CTRL,
  // Resets out and port input
  output src_pkg::src_rst_out_t RESET_OUT,
  output logic RESET_PIN_PORT_INPUT,
  // Interrupt
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (N_INT < 1 || STOP_WAIT_CYCLES < 1 || STAB_BASE_CYCLES < 1) begin : g_bad_count
    $error("src_standby_reset: counts must be positive");
  end
  if (STOP_WAIT_CYCLES + (STAB_BASE_CYCLES << 7) >= (1 << src_pkg::WAIT_W)) begin : g_bad_wait
    $error("src_standby_reset: wait exceeds counter");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  src_pkg::src_state_t state_q;
  src_pkg::src_state_t state_d;
  logic [src_pkg::WAIT_W-1:0] wait_q;
  logic reset_phase_q;
  logic lvd_cause_q;
  logic opt_done_q;
  logic port_mode_q;
  logic resonator_q;
  logic [2:0] stab_sel_q;
  logic [1:0] cause_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic pin_lvl;
  logic pin_rst;
  logic rst_src;
  logic wake;
  logic req;
  logic wr_fire;
  logic wr_ctrl;
  logic halt_req;
  logic stop_req;
  logic stab_done;
  logic [src_pkg::N_EVT-1:0] evt;
  logic [src_pkg::N_EVT-1:0] irq_stat;
  logic [src_pkg::N_EVT-1:0] irq_en;

  function automatic logic [src_pkg::WAIT_W-1:0] stab_cycles(input logic [2:0] sel);
    stab_cycles = src_pkg::WAIT_W'(STAB_BASE_CYCLES) << sel;
  endfunction : stab_cycles

  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  src_pin_sync #(
    .RST_VAL(1'b1)
  ) u_pin (
    .clk(CLK),
    .nrst(NRST),
    .din(RESET_PIN_N),
    .dout(pin_lvl)
  );

  // Port mode only counts once the option byte has been evaluated
  assign pin_rst = ~pin_lvl & (~port_mode_q | ~opt_done_q);
  assign rst_src = pin_rst | WDT_OVERFLOW | LOW_VOLTAGE_DETECTOR_RESET;
  assign wake = |(INT_REQ & ~INT_MASK);
  assign RESET_PIN_PORT_INPUT = pin_lvl;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      opt_done_q <= 1'b0;
      port_mode_q <= 1'b0;
    end else if (state_q == src_pkg::ST_RESET) begin
      opt_done_q <= 1'b0;
    end else if (OPT_VALID) begin
      opt_done_q <= 1'b1;
      port_mode_q <= OPT_PIN_AS_PORT;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign req = WB_CYC_I & WB_STB_I;
  assign wr_fire = req & WB_WE_I & ack_q & WB_SEL_I[0];
  assign wr_ctrl = wr_fire & (WB_ADR_I == src_pkg::ADR_CTRL);
  assign halt_req = wr_ctrl & WB_DAT_I[src_pkg::CTRL_HALT_BIT];
  assign stop_req = wr_ctrl & WB_DAT_I[src_pkg::CTRL_STOP_BIT];

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      unique case (WB_ADR_I)
        src_pkg::ADR_CTRL: dat_q <= {29'h0, resonator_q, 2'h0};
        src_pkg::ADR_STAB_SEL: dat_q <= {29'h0, stab_sel_q};
        src_pkg::ADR_STATUS: dat_q <= {24'h0, wake, port_mode_q, opt_done_q, pin_lvl,
                                       1'b0, state_q};
        // Whole word returned; single-bit reads are not supported
        src_pkg::ADR_CAUSE: dat_q <= {30'h0, cause_q};
        src_pkg::ADR_IRQ_STAT: dat_q <= {29'h0, irq_stat};
        src_pkg::ADR_IRQ_EN: dat_q <= {29'h0, irq_en};
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      resonator_q <= src_pkg::CTRL_RES_RST;
    end else if (wr_ctrl) begin
      resonator_q <= WB_DAT_I[src_pkg::CTRL_RES_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      stab_sel_q <= src_pkg::STAB_SEL_RST;
    end else if (wr_fire & (WB_ADR_I == src_pkg::ADR_STAB_SEL)) begin
      stab_sel_q <= WB_DAT_I[2:0];
    end
  end

  // Flags only cleared by power-on-clear
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cause_q <= src_pkg::CAUSE_RST;
    end else begin
      if (WDT_OVERFLOW) begin
        cause_q[src_pkg::CAUSE_WDT_BIT] <= 1'b1;
      end
      if (LOW_VOLTAGE_DETECTOR_RESET) begin
        cause_q[src_pkg::CAUSE_LVD_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby and reset sequencer
  // ----------------------------------------------------------------
  assign stab_done = (state_q == src_pkg::ST_STAB_WAIT) && (wait_q == '0);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      src_pkg::ST_RESET: begin
        if (!rst_src) begin
          state_d = src_pkg::ST_OSC_START;
        end
      end
      src_pkg::ST_RUN: begin
        // A pending request cancels the standby entry
        if (stop_req && !wake) begin
          state_d = src_pkg::ST_STOP;
        end else if (halt_req && !wake) begin
          state_d = src_pkg::ST_HALT;
        end
      end
      src_pkg::ST_HALT: begin
        if (wake) begin
          state_d = src_pkg::ST_RUN;
        end
      end
      src_pkg::ST_STOP: begin
        if (wake) begin
          state_d = src_pkg::ST_OSC_START;
        end
      end
      src_pkg::ST_OSC_START: begin
        // Count only after the oscillator has started
        if (OSC_READY) begin
          state_d = src_pkg::ST_STAB_WAIT;
        end
      end
      src_pkg::ST_STAB_WAIT: begin
        if (wait_q == '0) begin
          state_d = src_pkg::ST_RUN;
        end
      end
      default: state_d = src_pkg::ST_RESET;
    endcase
    if (rst_src) begin
      state_d = src_pkg::ST_RESET;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_q <= src_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      wait_q <= '0;
    end else if (state_q == src_pkg::ST_OSC_START && OSC_READY) begin
      if (reset_phase_q) begin
        wait_q <= stab_cycles(OPT_STAB_SEL) - 1'b1;
      end else if (resonator_q) begin
        wait_q <= src_pkg::WAIT_W'(STOP_WAIT_CYCLES) + stab_cycles(stab_sel_q)
                  - 1'b1;
      end else begin
        wait_q <= src_pkg::WAIT_W'(STOP_WAIT_CYCLES) - 1'b1;
      end
    end else if (state_q == src_pkg::ST_STAB_WAIT && wait_q != '0) begin
      wait_q <= wait_q - 1'b1;
    end
  end

  // Marks a release from reset rather than from stop
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      reset_phase_q <= 1'b1;
    end else if (rst_src) begin
      reset_phase_q <= 1'b1;
    end else if (stab_done) begin
      reset_phase_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      lvd_cause_q <= 1'b0;
    end else if (LOW_VOLTAGE_DETECTOR_RESET) begin
      lvd_cause_q <= 1'b1;
    end else if (state_q != src_pkg::ST_RESET) begin
      lvd_cause_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Clock and reset outputs
  // ----------------------------------------------------------------
  always_comb begin
    // Both oscillators off in reset; the fast one also in stop
    CLOCK_CTRL.sys_osc_en = (state_q != src_pkg::ST_RESET) &&
                            (state_q != src_pkg::ST_STOP);
    CLOCK_CTRL.lsi_osc_en = (state_q != src_pkg::ST_RESET);
    CLOCK_CTRL.cpu_clk_en = (state_q == src_pkg::ST_RUN);
    RESET_OUT.sys_rst_n = ~reset_phase_q;
    // Every reset source also clears the watchdog, its own included
    RESET_OUT.wdt_rst = (state_q == src_pkg::ST_RESET);
    // Detector keeps its state through a reset it raised itself
    RESET_OUT.lvd_rst = (state_q == src_pkg::ST_RESET) && !lvd_cause_q &&
                        !LOW_VOLTAGE_DETECTOR_RESET;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    evt = '0;
    evt[src_pkg::EVT_HALT_WAKE] = (state_q == src_pkg::ST_HALT) && wake && !rst_src;
    evt[src_pkg::EVT_STOP_DONE] = stab_done && !reset_phase_q && !rst_src;
    evt[src_pkg::EVT_RST_DONE] = stab_done && reset_phase_q && !rst_src;
  end

  src_irq #(
    .N(src_pkg::N_EVT)
  ) u_irq (
    .clk(CLK),
    .nrst(NRST),
    .evt(evt),
    .clr_we(wr_fire & (WB_ADR_I == src_pkg::ADR_IRQ_CLR)),
    .en_we(wr_fire & (WB_ADR_I == src_pkg::ADR_IRQ_EN)),
    .wdata(WB_DAT_I[src_pkg::N_EVT-1:0]),
    .status_q(irq_stat),
    .enable_q(irq_en),
    .irq(IRQ)
  );

endmodule : src_standby_reset

// >>> testbench/src_monitor.sv
`timescale 1ns/100ps
module src_monitor #(
  parameter int N_INT = 8,
  parameter int STAB_BASE_CYCLES = 256
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Bus handshake
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // Reset sources and option byte
  input wire logic WDT_OVERFLOW,
  input wire logic LOW_VOLTAGE_DETECTOR_RESET,
  input wire logic OPT_VALID,
  input wire logic OPT_PIN_AS_PORT,
  input wire logic RESET_PIN_PORT_INPUT,
  // Interrupts and clocks
  input wire logic [N_INT-1:0] INT_REQ,
  input wire logic [N_INT-1:0] INT_MASK,
  input wire logic OSC_READY,
  input wire src_pkg::src_clk_ctrl_t CLOCK_CTRL,
  input wire src_pkg::src_rst_out_t RESET_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic port_q;
  logic wait_q;
  logic [19:0] cnt_q;
  logic in_rst;
  logic pend;
  assign in_rst = RESET_OUT.wdt_rst;
  assign pend = |(INT_REQ & ~INT_MASK);
  // ----
  // Helpers
  // ----
  always_ff @(posedge CLK) begin
    if (!NRST || in_rst) port_q <= 1'h0;
    else if (OPT_VALID) port_q <= OPT_PIN_AS_PORT;
  end
  // Only stop or reset turn the oscillator off, so halt never arms this
  always_ff @(posedge CLK) begin
    if (!NRST || !CLOCK_CTRL.sys_osc_en) wait_q <= 1'h1;
    else if (CLOCK_CTRL.cpu_clk_en) wait_q <= 1'h0;
  end
  always_ff @(posedge CLK) begin
    if (!NRST || !CLOCK_CTRL.sys_osc_en) cnt_q <= 20'h0;
    else if (OSC_READY && !CLOCK_CTRL.cpu_clk_en) cnt_q <= cnt_q + 20'h1;
  end
  // ----
  // Properties
  // ----
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  wdt_reset_a: assert property (WDT_OVERFLOW |=> RESET_OUT.wdt_rst)
    else $error("watchdog reset missing");
  lvd_spared_a: assert property (LOW_VOLTAGE_DETECTOR_RESET && !in_rst |=> in_rst && !RESET_OUT.lvd_rst)
    else $error("detector reset hit the detector");
  reset_clocks_a: assert property (in_rst |-> !CLOCK_CTRL.sys_osc_en && !CLOCK_CTRL.lsi_osc_en)
    else $error("oscillator running in reset");
  pin_reset_a: assert property (!RESET_PIN_PORT_INPUT && !port_q |=> in_rst)
    else $error("low pin did not hold reset");
  stab_wait_a: assert property ($rose(CLOCK_CTRL.cpu_clk_en) && $past(wait_q) |-> cnt_q > STAB_BASE_CYCLES)
    else $error("resumed before stabilisation");
  halt_wake_a: assert property (pend && CLOCK_CTRL.sys_osc_en && !CLOCK_CTRL.cpu_clk_en && !wait_q && !in_rst && !WDT_OVERFLOW && !LOW_VOLTAGE_DETECTOR_RESET |=> CLOCK_CTRL.cpu_clk_en)
    else $error("halt not left on pending interrupt");
endmodule : src_monitor

// >>> testbench/src_far_side.sv
`timescale 1ns/100ps
module src_far_side #(
  parameter int OSC_DLY = 7,
  parameter int PIN_MIN = 250
) (
  // Clock
  input wire logic clk,
  // Oscillator
  input wire logic osc_en,
  output logic osc_ready,
  // Reset pin
  input wire logic pin_hold,
  output logic pin_n
);
  int osc_cnt = 0;
  int pin_cnt = 0;
  initial osc_ready = 1'h0;
  initial pin_n = 1'h1;
  // Oscillation starts some cycles after enable, never at once
  always @(posedge clk) begin
    osc_cnt <= osc_en ? osc_cnt + 1 : 0;
    osc_ready <= osc_en && osc_cnt >= OSC_DLY;
  end
  // A pin pulse never ends before the minimum low time
  always @(posedge clk) begin
    pin_cnt <= pin_hold ? PIN_MIN : (pin_cnt > 0 ? pin_cnt - 1 : 0);
    pin_n <= !(pin_hold || pin_cnt > 1);
  end
endmodule : src_far_side

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int SW = 20;
  localparam int SB = 4;
  logic CLK = 1'h0;
  logic NRST = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, wdt = 1'h0, lvd = 1'h0, optv = 1'h0;
  logic port = 1'h0, pin_hold = 1'h0, pin_n, ready, port_in, irq;
  logic [7:0] adr = 8'h00, req = 8'h00, msk = 8'h00, lfsr = 8'h57;
  logic [31:0] wdat = 32'h0, rd, rdat;
  logic [2:0] osel = 3'h1;
  src_pkg::src_clk_ctrl_t cc;
  src_pkg::src_rst_out_t ro;
  int fail_count = 0, num_checks = 0, n;
  always #4 CLK = ~CLK;
  src_standby_reset #(.N_INT(8), .STOP_WAIT_CYCLES(SW), .STAB_BASE_CYCLES(SB)) uut (
    .CLK(CLK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rd), .WB_ACK_O(ack), .RESET_PIN_N(pin_n),
    .WDT_OVERFLOW(wdt), .LOW_VOLTAGE_DETECTOR_RESET(lvd), .OPT_VALID(optv),
    .OPT_PIN_AS_PORT(port), .OPT_STAB_SEL(osel), .INT_REQ(req), .INT_MASK(msk),
    .OSC_READY(ready), .CLOCK_CTRL(cc), .RESET_OUT(ro), .RESET_PIN_PORT_INPUT(port_in),
    .IRQ(irq));
  src_far_side far (.clk(CLK), .osc_en(cc.sys_osc_en), .osc_ready(ready),
    .pin_hold(pin_hold), .pin_n(pin_n));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  function automatic int stab(input logic [2:0] s);
    return SB << s;
  endfunction : stab
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb} <= 2'h3;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge CLK);
    end while (ack !== 1'h1);
    rdat = rd;
    {cyc, stb} <= 2'h0;
    @(posedge CLK);
  endtask : wb
  // Counts ready cycles spent waiting before the core clock returns
  task automatic run_wait(input int exp);
    n = 0;
    for (int t = 0; t < 3000 && cc.cpu_clk_en !== 1'h1; t++) begin
      @(posedge CLK);
      if (ready && !cc.cpu_clk_en) n++;
    end
    check("stab", n, exp);
  endtask : run_wait
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge CLK);
    NRST <= 1'h1;
    run_wait(stab(osel) + 1);
    wb(1'h0, src_pkg::ADR_CAUSE, 32'h0);
    check("cause", rdat, 32'h0);
    wb(1'h0, src_pkg::ADR_STAB_SEL, 32'h0);
    check("sel", rdat, 32'h4);
    wb(1'h0, 8'h20, 32'h0);
    check("unmapped", rdat, 32'h0);
    wb(1'h1, src_pkg::ADR_IRQ_EN, 32'h7);
    for (int r = 1; r >= 0; r--) begin
      lfsr = nxt(lfsr);
      wb(1'h1, src_pkg::ADR_STAB_SEL, {29'h0, lfsr[2:0]});
      wb(1'h1, src_pkg::ADR_CTRL, {29'h0, r[0], 2'h2});
      repeat (3) @(posedge CLK);
      wb(1'h0, src_pkg::ADR_STATUS, 32'h0);
      check("stop", rdat[2:0], 32'h3);
      req <= 8'h01;
      run_wait(SW + (r == 1 ? stab(lfsr[2:0]) : 0) + 1);
      req <= 8'h00;
      wb(1'h0, src_pkg::ADR_IRQ_STAT, 32'h0);
      check("evt", {irq, rdat[1]}, 32'h3);
      wb(1'h1, src_pkg::ADR_IRQ_CLR, 32'h7);
      repeat (2) @(posedge CLK);
      check("irq clr", irq, 32'h0);
    end
    req <= 8'h02;
    wb(1'h1, src_pkg::ADR_CTRL, 32'h5);
    repeat (2) @(posedge CLK);
    check("no halt", cc.cpu_clk_en, 32'h1);
    msk <= 8'h02;
    wb(1'h1, src_pkg::ADR_CTRL, 32'h5);
    repeat (2) @(posedge CLK);
    check("halted", cc.cpu_clk_en, 32'h0);
    msk <= 8'h00;
    repeat (2) @(posedge CLK);
    check("wake", cc.cpu_clk_en, 32'h1);
    req <= 8'h00;
    osel <= lfsr[6:4];
    for (int k = 0; k < 2; k++) begin
      if (k == 0) wdt <= 1'h1;
      else lvd <= 1'h1;
      @(posedge CLK);
      {wdt, lvd} <= 2'h0;
      @(posedge CLK);
      check("rst", {ro.wdt_rst, ro.lvd_rst, cc.sys_osc_en}, {1'h1, k == 0, 1'h0});
      run_wait(stab(osel) + 1);
      wb(1'h0, src_pkg::ADR_CAUSE, 32'h0);
      check("cause", rdat, k == 0 ? 32'h1 : 32'h3);
    end
    pin_hold <= 1'h1;
    repeat (300) @(posedge CLK);
    pin_hold <= 1'h0;
    repeat (100) @(posedge CLK);
    check("pin rst", {ro.wdt_rst, ro.sys_rst_n}, 32'h2);
    run_wait(stab(osel) + 1);
    port <= 1'h1;
    optv <= 1'h1;
    @(posedge CLK);
    optv <= 1'h0;
    pin_hold <= 1'h1;
    repeat (300) @(posedge CLK);
    check("port", {cc.cpu_clk_en, port_in}, 32'h2);
    pin_hold <= 1'h0;
    NRST <= 1'h0;
    repeat (4) @(posedge CLK);
    NRST <= 1'h1;
    repeat (300) @(posedge CLK);
    wb(1'h0, src_pkg::ADR_CAUSE, 32'h0);
    check("por", rdat, 32'h0);
    give_verdict();
  end
endmodule : tb
bind src_standby_reset src_monitor #(.N_INT(N_INT), .STAB_BASE_CYCLES(STAB_BASE_CYCLES)) mon (
  .CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .WDT_OVERFLOW(WDT_OVERFLOW), .LOW_VOLTAGE_DETECTOR_RESET(LOW_VOLTAGE_DETECTOR_RESET),
  .OPT_VALID(OPT_VALID), .OPT_PIN_AS_PORT(OPT_PIN_AS_PORT),
  .RESET_PIN_PORT_INPUT(RESET_PIN_PORT_INPUT), .INT_REQ(INT_REQ), .INT_MASK(INT_MASK),
  .OSC_READY(OSC_READY), .CLOCK_CTRL(CLOCK_CTRL), .RESET_OUT(RESET_OUT));
